// ---- inc/mac_mgmt_pkg.sv ----
// Constants for the MAC management and pause control block.
// Assumes one core clock domain; the management clock arrives as a sampled pin.
package mac_mgmt_pkg;

  // Indirect register addresses.
  localparam logic [15:0] ADDR_MDIO_CMD   = 16'h0014;
  localparam logic [15:0] ADDR_MDIO_DATA  = 16'h0018;
  localparam logic [15:0] ADDR_FLOW_CTRL  = 16'h001C;
  localparam logic [15:0] ADDR_STATS_CTRL = 16'h0100;
  localparam logic [15:0] ADDR_RSVD_A     = 16'h010C;

  // Reset values.
  localparam logic [31:0] RST_MDIO_CMD   = 32'h00005AC0;
  localparam logic [15:0] RST_MDIO_DATA  = 16'h0000;
  localparam logic [15:0] RST_PAUSE_DUR  = 16'h0050;
  localparam logic        RST_FC_ENABLE  = 1'b1;
  localparam logic [31:0] RST_STATS_CTRL = 32'h00002F72;
  localparam logic [31:0] RST_RSVD_A     = 32'h00000000;

  // Command register fields.
  localparam int PHY_LSB     = 11;
  localparam int PHY_MSB     = 15;
  localparam int REGIDX_LSB  = 6;
  localparam int REGIDX_MSB  = 10;
  localparam int WRSEL_BIT   = 1;
  localparam int BUSY_BIT    = 0;

  // Flow control fields.
  localparam int PAUSE_LSB   = 16;
  localparam int PAUSE_MSB   = 31;
  localparam int FCE_BIT     = 1;
  localparam int PREQ_BIT    = 0;

  // Statistics control fields.
  localparam int MAXLEN_LSB  = 3;
  localparam int MAXLEN_MSB  = 13;

  // Management frame layout.
  localparam logic [31:0] MD_PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0]  MD_START    = 2'h1;
  localparam logic [1:0]  MD_OP_WRITE = 2'h1;
  localparam logic [1:0]  MD_OP_READ  = 2'h2;
  localparam logic [1:0]  MD_TA_WRITE = 2'h2;
  localparam logic [1:0]  MD_TA_READ  = 2'h3;
  localparam logic [5:0]  MD_TA_IDX   = 6'd46;
  localparam logic [5:0]  MD_DATA_IDX = 6'd48;
  localparam logic [5:0]  MD_LAST_IDX = 6'd63;

  typedef enum logic [2:0] {
    MD_IDLE  = 3'b001,
    MD_LEAD  = 3'b010,
    MD_SHIFT = 3'b100
  } md_state_e;

endpackage

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for pins from outside the core clock domain.
// Assumes the input is a level; the output lags it by two core clocks.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- rtl/mac_mdio_and_pause_control.sv ----
// MAC management registers: PHY management transactions and pause control.
// Assumes the indirect window logic presents one access per strobe and that
// the MAC datapath signals pause frame completion and frame lengths.
`timescale 1ns/1ps
module mac_mdio_and_pause_control #(
  parameter int LEN_W = 14
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Indirect register window
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             reg_ack,
  // Management bus
  input  wire logic        mdc_in,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // Pause transmit side
  output logic      [15:0] pause_duration,
  output logic             pause_tx_start,
  input  wire logic        pause_tx_done,
  // Pause receive side
  input  wire logic        rx_pause_valid,
  input  wire logic [15:0] rx_pause_quanta,
  input  wire logic        slot_tick,
  output logic             flow_ctrl_enable,
  output logic             tx_hold,
  // Long frame classification
  input  wire logic        tx_frame_done,
  input  wire logic [LEN_W-1:0] tx_frame_len,
  output logic             long_frame
);

  logic [4:0]  phy_select;
  logic [4:0]  phy_register_index;
  logic        mgmt_write_select;
  logic        mgmt_busy_flag;
  logic [15:0] mgmt_data_word;
  logic        pause_request_flag;
  logic [31:0] stats_control;
  logic [31:0] reserved_control_a;
  logic [15:0] pause_cnt;
  logic [15:0] next_pause_cnt;

  logic      mdc_s;
  logic      mdio_s;
  logic      mdc_d;
  logic      mdc_rise;
  logic      mdc_fall;
  mac_mgmt_pkg::md_state_e md_state;
  logic [63:0] md_shift;
  logic [5:0]  md_idx;
  logic [15:0] md_rx;
  logic        md_read_done;

  logic wr_cmd;
  logic wr_data;
  logic wr_fc;
  logic start_txn;
  logic md_finish;

  pin_sync #(.WIDTH(1)) u_sync_mdc (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (mdc_in),
    .sync_out (mdc_s)
  );

  pin_sync #(.WIDTH(1)) u_sync_mdio (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (mdio_in),
    .sync_out (mdio_s)
  );

  // Register window decode.
  assign wr_cmd  = reg_wr && (reg_addr == mac_mgmt_pkg::ADDR_MDIO_CMD);
  assign wr_data = reg_wr && (reg_addr == mac_mgmt_pkg::ADDR_MDIO_DATA);
  assign wr_fc   = reg_wr && (reg_addr == mac_mgmt_pkg::ADDR_FLOW_CTRL);
  // A command written while busy is dropped so a running frame is never corrupted.
  assign start_txn = wr_cmd && !mgmt_busy_flag;
  assign md_finish = (md_state == mac_mgmt_pkg::MD_SHIFT) && mdc_rise &&
                     (md_idx == mac_mgmt_pkg::MD_LAST_IDX);

  // Command register fields.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_select         <= mac_mgmt_pkg::RST_MDIO_CMD[mac_mgmt_pkg::PHY_MSB:mac_mgmt_pkg::PHY_LSB];
      phy_register_index <=
        mac_mgmt_pkg::RST_MDIO_CMD[mac_mgmt_pkg::REGIDX_MSB:mac_mgmt_pkg::REGIDX_LSB];
      mgmt_write_select  <= mac_mgmt_pkg::RST_MDIO_CMD[mac_mgmt_pkg::WRSEL_BIT];
    end else if (start_txn) begin
      phy_select         <= reg_wdata[mac_mgmt_pkg::PHY_MSB:mac_mgmt_pkg::PHY_LSB];
      phy_register_index <= reg_wdata[mac_mgmt_pkg::REGIDX_MSB:mac_mgmt_pkg::REGIDX_LSB];
      mgmt_write_select  <= reg_wdata[mac_mgmt_pkg::WRSEL_BIT];
    end
  end

  // Busy flag.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_busy_flag <= mac_mgmt_pkg::RST_MDIO_CMD[mac_mgmt_pkg::BUSY_BIT];
    end else if (start_txn) begin
      mgmt_busy_flag <= 1'b1;
    end else if (md_finish) begin
      mgmt_busy_flag <= 1'b0;
    end
  end

  // Data register; a finishing read overrides a software write in the same cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_data_word <= mac_mgmt_pkg::RST_MDIO_DATA;
    end else if (md_finish && !mgmt_write_select) begin
      mgmt_data_word <= {md_rx[14:0], mdio_s};
    end else if (wr_data) begin
      mgmt_data_word <= reg_wdata[15:0];
    end
  end

  // Management clock edge detection on the synchronised level.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mdc_d <= 1'b0;
    end else begin
      mdc_d <= mdc_s;
    end
  end
  assign mdc_rise = mdc_s && !mdc_d;
  assign mdc_fall = !mdc_s && mdc_d;

  // Frame engine: drive on the falling edge, sample on the rising edge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      md_state <= mac_mgmt_pkg::MD_IDLE;
      md_shift <= '0;
      md_idx   <= '0;
      md_rx    <= '0;
      mdio_out <= 1'b1;
      mdio_oe  <= 1'b0;
    end else begin
      case (md_state)
        mac_mgmt_pkg::MD_IDLE: begin
          if (start_txn) begin
            md_shift <= {mac_mgmt_pkg::MD_PREAMBLE, mac_mgmt_pkg::MD_START,
                         reg_wdata[mac_mgmt_pkg::WRSEL_BIT] ?
                           mac_mgmt_pkg::MD_OP_WRITE : mac_mgmt_pkg::MD_OP_READ,
                         reg_wdata[mac_mgmt_pkg::PHY_MSB:mac_mgmt_pkg::PHY_LSB],
                         reg_wdata[mac_mgmt_pkg::REGIDX_MSB:mac_mgmt_pkg::REGIDX_LSB],
                         reg_wdata[mac_mgmt_pkg::WRSEL_BIT] ?
                           mac_mgmt_pkg::MD_TA_WRITE : mac_mgmt_pkg::MD_TA_READ,
                         mgmt_data_word};
            md_state <= mac_mgmt_pkg::MD_LEAD;
          end
        end
        mac_mgmt_pkg::MD_LEAD: begin
          if (mdc_fall) begin
            mdio_out <= md_shift[63];
            mdio_oe  <= 1'b1;
            md_shift <= {md_shift[62:0], 1'b0};
            md_idx   <= '0;
            md_state <= mac_mgmt_pkg::MD_SHIFT;
          end
        end
        mac_mgmt_pkg::MD_SHIFT: begin
          if (mdc_fall) begin
            mdio_out <= md_shift[63];
            // Release the line for turnaround and data on a read.
            mdio_oe  <= mgmt_write_select || ((md_idx + 6'd1) < mac_mgmt_pkg::MD_TA_IDX);
            md_shift <= {md_shift[62:0], 1'b0};
            md_idx   <= md_idx + 6'd1;
          end else if (mdc_rise) begin
            if (md_idx >= mac_mgmt_pkg::MD_DATA_IDX) begin
              md_rx <= {md_rx[14:0], mdio_s};
            end
            if (md_idx == mac_mgmt_pkg::MD_LAST_IDX) begin
              mdio_oe  <= 1'b0;
              mdio_out <= 1'b1;
              md_state <= mac_mgmt_pkg::MD_IDLE;
            end
          end
        end
        default: begin
          md_state <= mac_mgmt_pkg::MD_IDLE;
          mdio_oe  <= 1'b0;
        end
      endcase
    end
  end
  assign md_read_done = md_finish && !mgmt_write_select;

  // Flow control fields and pause request; a request write beats a done pulse.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_duration     <= mac_mgmt_pkg::RST_PAUSE_DUR;
      flow_ctrl_enable   <= mac_mgmt_pkg::RST_FC_ENABLE;
      pause_request_flag <= 1'b0;
      pause_tx_start     <= 1'b0;
    end else begin
      pause_tx_start <= 1'b0;
      if (wr_fc) begin
        pause_duration   <= reg_wdata[mac_mgmt_pkg::PAUSE_MSB:mac_mgmt_pkg::PAUSE_LSB];
        flow_ctrl_enable <= reg_wdata[mac_mgmt_pkg::FCE_BIT];
      end
      if (wr_fc && reg_wdata[mac_mgmt_pkg::PREQ_BIT] && !pause_request_flag) begin
        pause_request_flag <= 1'b1;
        pause_tx_start     <= 1'b1;
      end else if (pause_tx_done && !(wr_fc && reg_wdata[mac_mgmt_pkg::PREQ_BIT])) begin
        pause_request_flag <= 1'b0;
      end
    end
  end

  // Receive pause hold-off, counted down one slot time per tick.
  always_comb begin
    next_pause_cnt = pause_cnt;
    if (rx_pause_valid && flow_ctrl_enable) begin
      next_pause_cnt = rx_pause_quanta;
    end else if (slot_tick && (pause_cnt != 16'h0000)) begin
      next_pause_cnt = pause_cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pause_cnt <= '0;
      tx_hold   <= 1'b0;
    end else begin
      pause_cnt <= next_pause_cnt;
      tx_hold   <= (next_pause_cnt != 16'h0000);
    end
  end

  // Statistics and reserved control registers; software keeps the reserved bit set.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stats_control      <= mac_mgmt_pkg::RST_STATS_CTRL;
      reserved_control_a <= mac_mgmt_pkg::RST_RSVD_A;
    end else if (reg_wr) begin
      if (reg_addr == mac_mgmt_pkg::ADDR_STATS_CTRL) begin
        stats_control <= reg_wdata;
      end
      if (reg_addr == mac_mgmt_pkg::ADDR_RSVD_A) begin
        reserved_control_a <= reg_wdata;
      end
    end
  end

  // Long frame flag, one cycle per oversize frame.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      long_frame <= 1'b0;
    end else begin
      long_frame <= tx_frame_done && (tx_frame_len >
        LEN_W'(stats_control[mac_mgmt_pkg::MAXLEN_MSB:mac_mgmt_pkg::MAXLEN_LSB]));
    end
  end

  // Register reads.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= reg_wr || reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          mac_mgmt_pkg::ADDR_MDIO_CMD:   reg_rdata <= {16'h0000, phy_select, phy_register_index,
                                                       4'h0, mgmt_write_select, mgmt_busy_flag};
          mac_mgmt_pkg::ADDR_MDIO_DATA:  reg_rdata <= {16'h0000, mgmt_data_word};
          mac_mgmt_pkg::ADDR_FLOW_CTRL:  reg_rdata <= {pause_duration, 14'h0000,
                                                       flow_ctrl_enable, pause_request_flag};
          mac_mgmt_pkg::ADDR_STATS_CTRL: reg_rdata <= stats_control;
          mac_mgmt_pkg::ADDR_RSVD_A:     reg_rdata <= reserved_control_a;
          default:                       reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- bench/mac_mdio_and_pause_control_chk.sv ----
// Checker for the MAC management and pause block, seen from its top ports.
// Assumes a single core clock domain with rst_b as its only reset.
`timescale 1ns/1ps
module mac_mdio_and_pause_control_chk (
  // Clock, reset and register window
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  // Management bus, pause and frame sides
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic [15:0] pause_duration,
  input wire logic        pause_tx_start,
  input wire logic        flow_ctrl_enable,
  input wire logic        rx_pause_valid,
  input wire logic [15:0] rx_pause_quanta,
  input wire logic        tx_hold,
  input wire logic        tx_frame_done,
  input wire logic        long_frame
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic fc_wr;
  logic preq_wr;
  assign fc_wr = reg_wr && reg_addr == 16'h001C;
  assign preq_wr = fc_wr && reg_wdata[0];
  property p_ack; reg_wr || reg_rd |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_rdhi; reg_rd && reg_addr == 16'h0018
    |=> reg_ack && reg_rdata[31:16] == 16'h0000; endproperty
  a_rdhi: assert property (p_rdhi) else $error("data upper half not zero");
  property p_pdur; fc_wr |=> pause_duration == $past(reg_wdata[31:16]); endproperty
  a_pdur: assert property (p_pdur) else $error("pause time not taken");
  property p_fce; fc_wr |=> flow_ctrl_enable == $past(reg_wdata[1]); endproperty
  a_fce: assert property (p_fce) else $error("flow enable not taken");
  property p_hold; rx_pause_valid && flow_ctrl_enable
    |=> tx_hold == ($past(rx_pause_quanta) != 16'h0000); endproperty
  a_hold: assert property (p_hold) else $error("hold not loaded");
  property p_start; pause_tx_start |-> $past(preq_wr); endproperty
  a_start: assert property (p_start) else $error("pause start uncaused");
  property p_long; long_frame |-> $past(tx_frame_done); endproperty
  a_long: assert property (p_long) else $error("long flag uncaused");
  property p_pre; $rose(mdio_oe) |-> mdio_out; endproperty
  a_pre: assert property (p_pre) else $error("frame not opened by one");
  c_start: cover property (pause_tx_start);
  c_frame: cover property ($fell(mdio_oe));
  c_long: cover property (long_frame);
endmodule

// ---- bench/phy_model.sv ----
// Behavioural PHY on the management bus: captures each frame, answers reads.
// Assumes the bench runs mdc only while a transaction is pending.
`timescale 1ns/1ps
module phy_model (
  // Bus
  input  wire logic        mdc,
  input  wire logic        md,
  input  wire logic        mdio_oe,
  // Answer and capture
  input  wire logic [15:0] rd_word,
  output logic             phy_out,
  output logic             phy_oe,
  output logic [63:0]      frame
);
  initial begin
    phy_oe = 1'b0;
    phy_out = 1'b1;
    frame = 64'h0;
    forever begin
      @(posedge mdio_oe);
      for (int i = 0; i < 64; i++) begin
        @(posedge mdc);
        frame[63-i] = md;
        if (frame[29:28] == 2'b10 && i >= 46 && i < 63) begin
          @(negedge mdc);
          phy_oe = 1'b1;
          phy_out = (i == 46) ? 1'b0 : rd_word[62-i];
        end
      end
      // Hold the last bit past the device's sampling delay, then let the pull-up win.
      #200;
      phy_oe = 1'b0;
    end
  end
endmodule

// ---- bench/mac_mdio_and_pause_control_tb.sv ----
// Self-checking bench for the MAC management and pause control block.
// Assumes the checker and PHY model are compiled before this file.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module mac_mdio_and_pause_control_tb;
  logic        core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_ack;
  logic [15:0] reg_addr = 0, rd_word = 16'h3C96, pause_duration, rx_pause_quanta = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic        mdc = 1, run = 0, md, mdio_out, mdio_oe, phy_out, phy_oe;
  logic        pause_tx_start, pause_tx_done = 0, rx_pause_valid = 0, slot_tick = 0;
  logic        flow_ctrl_enable, tx_hold, tx_frame_done = 0, long_frame;
  logic [13:0] tx_frame_len = 0;
  logic [63:0] frame;
  int          failures = 0;
  int          num_checks = 0;
  logic [15:0] ra [6] = '{16'h0014, 16'h0018, 16'h001C, 16'h0100, 16'h010C, 16'h0020};
  logic [31:0] rv [6] = '{32'h00005AC0, 32'h0, 32'h00500002, 32'h00002F72, 32'h0, 32'h0};

  always #25 core_clk = ~core_clk;
  // The link clock stands at one between transactions; odd offset keeps it unrelated.
  initial begin
    #13;
    forever #200 mdc = run ? ~mdc : 1'b1;
  end
  assign md = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

  mac_mdio_and_pause_control dut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .mdc_in(mdc), .mdio_in(md), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .pause_duration(pause_duration), .pause_tx_start(pause_tx_start),
    .pause_tx_done(pause_tx_done), .rx_pause_valid(rx_pause_valid),
    .rx_pause_quanta(rx_pause_quanta), .slot_tick(slot_tick),
    .flow_ctrl_enable(flow_ctrl_enable), .tx_hold(tx_hold),
    .tx_frame_done(tx_frame_done), .tx_frame_len(tx_frame_len), .long_frame(long_frame));
  phy_model phy (.mdc(mdc), .md(md), .mdio_oe(mdio_oe), .rd_word(rd_word),
    .phy_out(phy_out), .phy_oe(phy_oe), .frame(frame));

  task automatic give_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    // The acknowledge stands for one cycle only, so take it before the next edge.
    d = reg_rdata;
    `CHK(reg_ack, 1'b1)
    reg_rd = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  // A command written while busy must leave the running one untouched.
  task automatic mdio_run(input logic [31:0] cmd);
    wr(16'h0014, cmd);
    run = 1'b1;
    rd(16'h0014);
    `CHK(d[0], 1'b1)
    wr(16'h0014, 32'h0);
    for (int n = 0; n < 400 && d[0] !== 1'b0; n++)
      rd(16'h0014);
    `CHK(d, cmd & 32'h0000FFC2)
    run = 1'b0;
  endtask

  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    wr(16'h0020, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      `CHK(d, rv[i])
    end
    wr(16'h0100, 32'h00000322);
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk);
      tx_frame_len = 14'(100 + i);
      tx_frame_done = 1'b1;
      @(negedge core_clk);
      tx_frame_done = 1'b0;
      `CHK(long_frame, i[0])
    end
    wr(16'h0018, 32'h0000A5C3);
    mdio_run(32'h00009A82);
    `CHK(frame, {32'hFFFFFFFF, 4'h5, 5'h13, 5'h0A, 2'b10, 16'hA5C3})
    mdio_run(32'h00000FC0);
    `CHK(frame[63:18], {32'hFFFFFFFF, 4'h6, 5'h01, 5'h1F})
    rd(16'h0018);
    `CHK(d, 32'h00003C96)
    wr(16'h001C, 32'h12340003);
    `CHK(pause_tx_start, 1'b1)
    wr(16'h001C, 32'h12340003);
    `CHK(pause_tx_start, 1'b0)
    rd(16'h001C);
    `CHK(d, 32'h12340003)
    pulse(pause_tx_done);
    rd(16'h001C);
    `CHK(d, 32'h12340002)
    `CHK(pause_duration, 16'h1234)
    rx_pause_quanta = 16'h0003;
    pulse(rx_pause_valid);
    `CHK(tx_hold, 1'b1)
    repeat (2) pulse(slot_tick);
    `CHK(tx_hold, 1'b1)
    pulse(slot_tick);
    @(negedge core_clk);
    `CHK(tx_hold, 1'b0)
    wr(16'h001C, 32'h12340000);
    pulse(rx_pause_valid);
    `CHK(tx_hold, 1'b0)
    give_verdict();
  end
endmodule

bind mac_mdio_and_pause_control mac_mdio_and_pause_control_chk u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .pause_duration(pause_duration),
  .pause_tx_start(pause_tx_start), .flow_ctrl_enable(flow_ctrl_enable),
  .rx_pause_valid(rx_pause_valid), .rx_pause_quanta(rx_pause_quanta),
  .tx_hold(tx_hold), .tx_frame_done(tx_frame_done), .long_frame(long_frame));
